// file: core/pte_unit.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pte_defs.svh"

// Overview of operation
// R1: writing 1 to polarity task applies configured set, clear, toggle or nothing
// R2: writing 1 to drive-high task at 0x030 forces the pin high
// R3: writing 1 to drive-low task at 0x060 forces the pin low
// R4: per-channel event flag at 0x100 plus 4n, readable and writable
// R5: port event flag at 0x17C set by sense activity
// R6: enable-set register sets interrupt enables; read returns enables
// R7: enable-clear register clears interrupt enables; read returns enables
// R8: mode 0 leaves the pin to the port logic
// R9: mode 1 makes pin an input and raises event on polarity condition
// R10: mode 3 makes pin an output driven by the channel tasks
// R11: in task mode ordinary port writes to the pin are ignored
// R12: five-bit pin select names the one pin per channel
// R13: task-mode polarity: none, high, low, toggle
// R14: event-mode polarity: never, rising, falling, any change
// R15: initial level sets task-mode pin level on configuration
// R16: same-cycle tasks: polarity beats low beats high
// R17: port event raised on rising edge of detect
// R18: event mode overrides port direction; disabled keeps port setup
// R19: software assigns each pin to at most one channel
// R20: irq while any enabled flag set; write 0 clears flag; task 0 ignored
module pte_unit #(
  parameter int NCH = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] port_out,
  input  wire logic [31:0] port_dir,
  input  wire logic [31:0] pin_in,
  input  wire logic        port_detect,
  output logic [31:0]      pin_out,
  output logic [31:0]      pin_oe,
  output logic             irq
);

  if (NCH < 1 || NCH > 8) begin
    $error("pte_unit: NCH must be 1..8");
  end

  function automatic logic [NCH-1:0] ch_hits(input logic [11:0] a, input logic [11:0] base);
    logic [NCH-1:0] r;
    r = '0;
    for (int i = 0; i < NCH; i++) begin
      if (a == base + 12'(i * 4)) r[i] = 1'b1;
    end
    return r;
  endfunction

  // write channel: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode
  wire [NCH-1:0] hit_pol_w  = ch_hits(aw_addr, `PTE_OFS_POL_TASK);
  wire [NCH-1:0] hit_high_w = ch_hits(aw_addr, `PTE_OFS_HIGH_TASK);
  wire [NCH-1:0] hit_low_w  = ch_hits(aw_addr, `PTE_OFS_LOW_TASK);
  wire [NCH-1:0] hit_ev_w   = ch_hits(aw_addr, `PTE_OFS_IN_EVENT);
  wire [NCH-1:0] hit_cfg_w  = ch_hits(aw_addr, `PTE_OFS_SETUP);
  wire           hit_port_w = aw_addr == `PTE_OFS_PORT_EVENT;
  wire           hit_ies_w  = aw_addr == `PTE_OFS_IEN_SET;
  wire           hit_iec_w  = aw_addr == `PTE_OFS_IEN_CLR;
  wire           wr_known   = |{hit_pol_w, hit_high_w, hit_low_w, hit_ev_w, hit_cfg_w,
                                hit_port_w, hit_ies_w, hit_iec_w};
  wire           b0         = w_strb[0] && w_data[0];
  wire           wr_lane0   = wr_go && w_strb[0];

  // unmapped addresses answer with an error and change nothing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PTE_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `PTE_RESP_OKAY : `PTE_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // task triggers: writing 0 does nothing
  // R20 zero ignored
  wire [NCH-1:0] trig_pol  = (wr_go && b0) ? hit_pol_w : '0;
  wire [NCH-1:0] trig_high = (wr_go && b0) ? hit_high_w : '0;
  wire [NCH-1:0] trig_low  = (wr_go && b0) ? hit_low_w : '0;

  // channel setup, task pin levels, events
  pte_pkg::pte_setup_t cfg [NCH];
  logic [NCH-1:0]      lvl;
  logic [NCH-1:0]      ev_flag;
  logic                port_flag;
  logic [NCH:0]        ien;
  logic                detect_d;
  // previous pin sample, so one level change gives exactly one edge
  logic [31:0]         pin_in_d;

  logic [NCH-1:0]      next_lvl;
  logic [NCH-1:0]      ev_hit;
  pte_pkg::pte_setup_t wcfg;

  logic [NCH:0] ien_wr;
  always_comb begin
    ien_wr = '0;
    for (int i = 0; i < NCH; i++) ien_wr[i] = w_strb[0] && w_data[i];
    ien_wr[NCH] = w_strb[3] && w_data[`PTE_PORT_BIT];
  end

  assign wcfg = pte_pkg::pte_setup_t'({w_data[`PTE_INIT_BIT],
                                       w_data[`PTE_POL_LSB+1:`PTE_POL_LSB],
                                       w_data[`PTE_PSEL_LSB+4:`PTE_PSEL_LSB],
                                       w_data[`PTE_MODE_LSB+1:`PTE_MODE_LSB]});

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      next_lvl[i] = lvl[i];
      // R16 task priority
      // one bus write at a time: the order matters once trigger inputs are added
      if (trig_pol[i]) begin
        // R1 polarity action
        // R13 task polarity
        unique case (cfg[i].polarity)
          `PTE_POL_NONE:   next_lvl[i] = lvl[i];
          `PTE_POL_RISE:   next_lvl[i] = 1'b1;
          `PTE_POL_FALL:   next_lvl[i] = 1'b0;
          `PTE_POL_TOGGLE: next_lvl[i] = !lvl[i];
        endcase
      end else if (trig_low[i]) begin
        // R3 drive low
        next_lvl[i] = 1'b0;
      end else if (trig_high[i]) begin
        // R2 drive high
        next_lvl[i] = 1'b1;
      end
      // R15 initial level
      if (wr_lane0 && hit_cfg_w[i] && wcfg.mode == `PTE_MODE_TASK) begin
        next_lvl[i] = w_strb[2] ? wcfg.init_level : lvl[i];
      end
      // R9 event on polarity
      // R14 event polarity
      // R12 pin select
      ev_hit[i] = 1'b0;
      if (cfg[i].mode == `PTE_MODE_EVENT) begin
        unique case (cfg[i].polarity)
          `PTE_POL_NONE:   ev_hit[i] = 1'b0;
          `PTE_POL_RISE:   ev_hit[i] = pin_in[cfg[i].psel] && !pin_in_d[cfg[i].psel];
          `PTE_POL_FALL:   ev_hit[i] = !pin_in[cfg[i].psel] && pin_in_d[cfg[i].psel];
          `PTE_POL_TOGGLE: ev_hit[i] = pin_in[cfg[i].psel] != pin_in_d[cfg[i].psel];
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) cfg[i] <= '0;
      lvl       <= '0;
      ev_flag   <= '0;
      port_flag <= 1'b0;
      ien       <= '0;
      detect_d  <= 1'b0;
      pin_in_d  <= 32'h00000000;
    end else begin
      lvl      <= next_lvl;
      detect_d <= port_detect;
      pin_in_d <= pin_in;
      for (int i = 0; i < NCH; i++) begin
        // byte lanes: mode in lane 0, pin in lane 1, polarity and level in lane 2
        if (wr_go && hit_cfg_w[i]) begin
          if (w_strb[0]) cfg[i].mode <= wcfg.mode;
          if (w_strb[1]) cfg[i].psel <= wcfg.psel;
          if (w_strb[2]) cfg[i].polarity <= wcfg.polarity;
          if (w_strb[2]) cfg[i].init_level <= wcfg.init_level;
        end
        // R4 event flag
        // R20 set beats clear
        if (ev_hit[i]) ev_flag[i] <= 1'b1;
        else if (wr_lane0 && hit_ev_w[i]) ev_flag[i] <= w_data[0];
      end
      // R17 detect rising edge
      // R5 port flag
      if (port_detect && !detect_d) port_flag <= 1'b1;
      else if (wr_lane0 && hit_port_w) port_flag <= w_data[0];
      // R6 enable set
      if (wr_go && hit_ies_w) ien <= ien | ien_wr;
      // R7 enable clear
      else if (wr_go && hit_iec_w) ien <= ien & ~ien_wr;
    end
  end

  // pin muxing
  pte_pkg::pte_pinword_t task_drv [NCH+1];
  logic [31:0]           ev_own;
  always_comb begin
    task_drv[0] = '0;
    ev_own      = 32'h00000000;
    for (int i = 0; i < NCH; i++) begin
      task_drv[i+1] = task_drv[i];
      // R10 task output
      // R19 one owner per pin
      if (cfg[i].mode == `PTE_MODE_TASK) begin
        task_drv[i+1].ena = 1'b1;
        task_drv[i+1].dat[cfg[i].psel] = next_lvl[i];
      end
      if (cfg[i].mode == `PTE_MODE_EVENT) ev_own[cfg[i].psel] = 1'b1;
    end
  end

  logic [31:0] task_own;
  always_comb begin
    task_own = 32'h00000000;
    for (int i = 0; i < NCH; i++) begin
      if (cfg[i].mode == `PTE_MODE_TASK) task_own[cfg[i].psel] = 1'b1;
    end
  end

  // R11 port writes ignored
  // R18 direction override
  // R8 disabled passthrough
  wire [31:0] next_out = (task_own & task_drv[NCH].dat) | (~task_own & port_out);
  wire [31:0] next_oe  = task_own | (~task_own & ~ev_own & port_dir);

  // R20 interrupt line
  wire next_irq = |({port_flag, ev_flag} & ien);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 32'h00000000;
      pin_oe  <= 32'h00000000;
      irq     <= 1'b0;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
      irq     <= next_irq;
    end
  end

  // read channel
  wire [NCH-1:0] hit_ev_r   = ch_hits(s_axi_araddr, `PTE_OFS_IN_EVENT);
  wire [NCH-1:0] hit_cfg_r  = ch_hits(s_axi_araddr, `PTE_OFS_SETUP);
  wire [NCH-1:0] hit_wo_r   = ch_hits(s_axi_araddr, `PTE_OFS_POL_TASK)
                            | ch_hits(s_axi_araddr, `PTE_OFS_HIGH_TASK)
                            | ch_hits(s_axi_araddr, `PTE_OFS_LOW_TASK);
  wire           hit_port_r = s_axi_araddr == `PTE_OFS_PORT_EVENT;
  wire           hit_ien_r  = s_axi_araddr == `PTE_OFS_IEN_SET
                            || s_axi_araddr == `PTE_OFS_IEN_CLR;

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h00000000;
    for (int i = 0; i < NCH; i++) begin
      if (hit_ev_r[i]) rd_val = {31'h00000000, ev_flag[i]};
      if (hit_cfg_r[i]) begin
        rd_val[`PTE_MODE_LSB+1:`PTE_MODE_LSB] = cfg[i].mode;
        rd_val[`PTE_PSEL_LSB+4:`PTE_PSEL_LSB] = cfg[i].psel;
        rd_val[`PTE_POL_LSB+1:`PTE_POL_LSB]   = cfg[i].polarity;
        rd_val[`PTE_INIT_BIT]                 = cfg[i].init_level;
      end
    end
    if (hit_port_r) rd_val = {31'h00000000, port_flag};
    if (hit_ien_r) begin
      rd_val[NCH-1:0]      = ien[NCH-1:0];
      rd_val[`PTE_PORT_BIT] = ien[NCH];
    end
  end
  wire rd_known = |{hit_ev_r, hit_cfg_r, hit_wo_r, hit_port_r, hit_ien_r};
  wire ar_take  = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PTE_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_known ? `PTE_RESP_OKAY : `PTE_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: include/pte_defs.svh
`ifndef PTE_DEFS_SVH
`define PTE_DEFS_SVH

`define PTE_OFS_POL_TASK   12'h000
`define PTE_OFS_HIGH_TASK  12'h030
`define PTE_OFS_LOW_TASK   12'h060
`define PTE_OFS_IN_EVENT   12'h100
`define PTE_OFS_PORT_EVENT 12'h17C
`define PTE_OFS_IEN_SET    12'h304
`define PTE_OFS_IEN_CLR    12'h308
`define PTE_OFS_SETUP      12'h510
`define PTE_ARRAY_SPAN     12'h020

`define PTE_MODE_LSB       0
`define PTE_PSEL_LSB       8
`define PTE_POL_LSB        16
`define PTE_INIT_BIT       20
`define PTE_PORT_BIT       31

`define PTE_MODE_OFF       2'h0
`define PTE_MODE_EVENT     2'h1
`define PTE_MODE_TASK      2'h3
`define PTE_POL_NONE       2'h0
`define PTE_POL_RISE       2'h1
`define PTE_POL_FALL       2'h2
`define PTE_POL_TOGGLE     2'h3

`define PTE_RESP_OKAY      2'h0
`define PTE_RESP_SLVERR    2'h2

`endif

// file: include/pte_pkg.sv
package pte_pkg;
  typedef struct packed {
    logic       init_level;
    logic [1:0] polarity;
    logic [4:0] psel;
    logic [1:0] mode;
  } pte_setup_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ena;
  } pte_pinword_t;
endpackage

// file: testbench/pte_pin_model.sv
`timescale 1ns/1ps
module pte_pin_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_lvl,
  input  wire logic        ext_det,
  output logic      [31:0] pin_in,
  output logic             port_detect
);
  // undriven pins show the outside level, never the unit's stale output
  always_ff @(posedge clk_sys) begin
    pin_in      <= (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
    port_detect <= ext_det;
  end
endmodule

// file: testbench/pte_unit_checker.sv
`timescale 1ns/1ps
module pte_unit_checker (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_refused:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  a_ar_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_task_reads_zero:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < 12'h020
      |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0) else $error("task read not zero");
  a_unmapped_write:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 12'h200
      |-> ##[1:3] s_axi_bvalid && s_axi_bresp == 2'h2) else $error("unmapped write okay");
  a_reset_quiet:
    assert property ($rose(rstn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("busy after reset");
endmodule
bind pte_unit pte_unit_checker u_pte_unit_checker (.clk_sys, .rstn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);

// file: testbench/pte_unit_tb_top.sv
`timescale 1ns/1ps
`include "pte_defs.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h seen %0h", n, e, s); end end
module pte_unit_tb_top;
  logic        clk_sys, rstn, ext_det, port_detect, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, port_out, port_dir, pin_in, pin_out, pin_oe, ext_lvl;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_count, n_compared;
  pte_unit u_pte_unit (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_out, .port_dir, .pin_in, .port_detect, .pin_out,
    .pin_oe, .irq);
  pte_pin_model u_pte_pin_model (.clk_sys, .pin_out, .pin_oe, .ext_lvl, .ext_det, .pin_in,
    .port_detect);
  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [4:0] s,
                                      input logic [1:0] pl, input logic i);
    cfg = {11'h0, i, 2'h0, pl, 3'h0, s, 6'h0, m};
  endfunction
  task automatic wc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
    // let the effect reach the registered pins
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
  initial begin
    {rstn, ext_det, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {port_out, ext_lvl, err_count, n_compared} = '0;
    s_axi_wstrb = 4'hF;
    port_dir = 32'hFFFF_FFFF;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rc(`PTE_OFS_POL_TASK, 32'h0, 2'h0);
    rc(`PTE_OFS_IN_EVENT, 32'h0, 2'h0);
    rc(`PTE_OFS_PORT_EVENT, 32'h0, 2'h0);
    rc(`PTE_OFS_IEN_SET, 32'h0, 2'h0);
    rc(12'h200, 32'h0, 2'h2);
    wc(12'h200, 32'h1, 2'h2);
    // pins 5, 31 and 9 each belong to one channel only
    wc(`PTE_OFS_SETUP, cfg(2'h3, 5'd5, 2'h0, 1'b1), 2'h0);
    `CHK("oe5", 1'b1, pin_oe[5])
    `CHK("lvl5", 1'b1, pin_out[5])
    wc(`PTE_OFS_LOW_TASK, 32'h1, 2'h0);
    `CHK("lvl5", 1'b0, pin_out[5])
    wc(`PTE_OFS_HIGH_TASK, 32'h0, 2'h0);
    `CHK("lvl5", 1'b0, pin_out[5])
    wc(`PTE_OFS_HIGH_TASK, 32'h1, 2'h0);
    `CHK("lvl5", 1'b1, pin_out[5])
    for (int p = 0; p < 4; p++) begin
      wc(`PTE_OFS_SETUP + 12'h8, cfg(2'h3, 5'd31, p[1:0], p == 2), 2'h0);
      wc(`PTE_OFS_POL_TASK + 12'h8, 32'h1, 2'h0);
      `CHK("pol31", p[0], pin_out[31])
    end
    wc(`PTE_OFS_SETUP, cfg(2'h0, 5'd5, 2'h3, 1'b1), 2'h0);
    port_out <= 32'h20;
    port_dir <= 32'hFFFF_FFDF;
    repeat (3) @(posedge clk_sys);
    `CHK("dis5", 1'b1, pin_out[5])
    `CHK("oe5d", 1'b0, pin_oe[5])
    for (int p = 0; p < 4; p++) begin
      wc(`PTE_OFS_SETUP + 12'h4, cfg(2'h1, 5'd9, p[1:0], 1'b1), 2'h0);
      `CHK("oe9", 1'b0, pin_oe[9])
      wc(`PTE_OFS_IN_EVENT + 12'h4, 32'h0, 2'h0);
      ext_lvl[9] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rc(`PTE_OFS_IN_EVENT + 12'h4, {31'h0, p[0]}, 2'h0);
      wc(`PTE_OFS_IN_EVENT + 12'h4, 32'h0, 2'h0);
      ext_lvl[9] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rc(`PTE_OFS_IN_EVENT + 12'h4, {31'h0, p[1]}, 2'h0);
    end
    wc(`PTE_OFS_IEN_SET, 32'h8000_0002, 2'h0);
    rc(`PTE_OFS_IEN_CLR, 32'h8000_0002, 2'h0);
    `CHK("irq", 1'b1, irq)
    wc(`PTE_OFS_IEN_CLR, 32'h2, 2'h0);
    `CHK("irq", 1'b0, irq)
    rc(`PTE_OFS_IEN_SET, 32'h8000_0000, 2'h0);
    ext_det <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_det <= 1'b0;
    rc(`PTE_OFS_PORT_EVENT, 32'h1, 2'h0);
    `CHK("irq", 1'b1, irq)
    wc(`PTE_OFS_PORT_EVENT, 32'h0, 2'h0);
    `CHK("irq", 1'b0, irq)
    test_done();
  end
endmodule
